// File: src/srr_params.svh
`ifndef SRR_PARAMS_SVH
`define SRR_PARAMS_SVH
`define SRR_CLK_PERIOD_NS   10
`define SRR_TRFC_NS         260
`define SRR_TRFC_CYC        ((`SRR_TRFC_NS + `SRR_CLK_PERIOD_NS - 1) / `SRR_CLK_PERIOD_NS)
`define SRR_TXS_EXTRA_NS    10
`define SRR_TXS_CYC         ((`SRR_TRFC_NS + `SRR_TXS_EXTRA_NS + `SRR_CLK_PERIOD_NS - 1) / `SRR_CLK_PERIOD_NS)
`define SRR_TXS_ABORT_NS    40
`define SRR_TXS_ABORT_CYC   ((`SRR_TXS_ABORT_NS + `SRR_CLK_PERIOD_NS - 1) / `SRR_CLK_PERIOD_NS)
`define SRR_TXSFAST_NS      40
`define SRR_TXSFAST_CYC     ((`SRR_TXSFAST_NS + `SRR_CLK_PERIOD_NS - 1) / `SRR_CLK_PERIOD_NS)
`define SRR_TXSDLL_CYC      768
`define SRR_TRP_NS          14
`define SRR_TRP_CYC         ((`SRR_TRP_NS + `SRR_CLK_PERIOD_NS - 1) / `SRR_CLK_PERIOD_NS)
`define SRR_TCKESR_CYC      6
`define SRR_TCKE_CYC        5
`define SRR_TCKSRE_CYC      10
`define SRR_TCKSRX_CYC      10
`define SRR_TREFI_NS        7800
`define SRR_TREFI_CYC       ((`SRR_TREFI_NS) / `SRR_CLK_PERIOD_NS)
`define SRR_POST_1X         8
`define SRR_ROW_W           15
`define SRR_CNT_W           16
`define SRR_DEBT_W          8
`endif

// File: src/srr_pkg.sv
package srr_pkg;
    // refresh granularity: 1x, 2x, 4x
    typedef enum logic [1:0] {
        SRR_MODE_1X = 2'h0,
        SRR_MODE_2X = 2'h1,
        SRR_MODE_4X = 2'h2
    } srr_mode_t;
    // device state, one-hot
    typedef enum logic [4:0] {
        SRR_DEV_IDLE  = 5'h01,
        SRR_DEV_REF   = 5'h02,
        SRR_DEV_SREF  = 5'h04,
        SRR_DEV_EXIT  = 5'h08,
        SRR_DEV_DLL   = 5'h10
    } srr_dev_t;
    // controller state, one-hot
    typedef enum logic [5:0] {
        SRR_CTL_IDLE  = 6'h01,
        SRR_CTL_TRFC  = 6'h02,
        SRR_CTL_ENDES = 6'h04,
        SRR_CTL_SREF  = 6'h08,
        SRR_CTL_CKRUN = 6'h10,
        SRR_CTL_EXIT  = 6'h20
    } srr_ctl_t;
endpackage

// File: src/srr_link_if.sv
`timescale 1ns/100ps
// command/address bus between controller and device
interface srr_link_if;
    logic                    cs_n;
    logic                    act_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic                    cke;
    logic                    odt;
    logic                    ck_en;
    logic [14:0]             addr;
    modport ctl (output cs_n, act_n, ras_n, cas_n, we_n, cke, odt, ck_en, addr);
    modport dev (input  cs_n, act_n, ras_n, cas_n, we_n, cke, odt, ck_en, addr);
endinterface

// File: src/srr_device.sv
`timescale 1ns/100ps
`include "srr_params.svh"
// device end: refresh engine, self refresh, termination and dll control
module srr_device #(
    parameter int TREFI_CYC  = `SRR_TREFI_CYC,
    parameter int TXSDLL_CYC = `SRR_TXSDLL_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    srr_link_if.dev                      link,
    input  wire logic                    abort_en_i,
    input  wire logic                    park_en_i,
    input  wire logic                    dll_used_i,
    output logic                         busy_o,
    output logic                         banks_idle_o,
    output logic                         in_sref_o,
    output logic                         rtt_park_o,
    output logic                         dll_on_o,
    output logic                         dll_reset_o,
    output logic [`SRR_ROW_W-1:0]        ref_row_o,
    output logic [`SRR_CNT_W-1:0]        ref_count_o,
    output logic                         cmd_err_o
);
    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    srr_pkg::srr_dev_t           state;
    srr_pkg::srr_dev_t           next_state;
    logic [15:0]                 tmr;
    logic [15:0]                 sref_tmr;
    logic                        cke_q;
    logic                        sel;
    logic                        ref_code;
    logic                        is_ref;
    logic                        is_sre;
    logic                        is_srx;
    logic                        is_des;
    logic                        tmr_done;
    logic                        int_ref;
    logic                        do_ref;
    logic                        ref_ok;

    assign sel      = ~link.cs_n;
    assign ref_code = sel & ~link.ras_n & ~link.cas_n & link.we_n & link.act_n;
    assign is_ref   = ref_code & link.cke & cke_q;
    assign is_sre   = ref_code & ~link.cke & cke_q;
    assign is_des   = link.cs_n;
    assign is_srx   = link.cke & ~cke_q & is_des;
    assign tmr_done = (tmr == 16'h0000);
    assign int_ref  = (state == srr_pkg::SRR_DEV_SREF) && (sref_tmr == 16'h0000);
    // refresh taken once tXS is over, even while the dll relocks
    assign ref_ok   = (state == srr_pkg::SRR_DEV_IDLE) || (state == srr_pkg::SRR_DEV_DLL);
    assign do_ref   = (is_ref && ref_ok) || int_ref;

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            srr_pkg::SRR_DEV_IDLE: begin
                if (is_ref) begin
                    next_state = srr_pkg::SRR_DEV_REF;
                end else if (is_sre) begin
                    next_state = srr_pkg::SRR_DEV_SREF;
                end
            end
            srr_pkg::SRR_DEV_REF: begin
                if (tmr_done) begin
                    next_state = srr_pkg::SRR_DEV_IDLE;
                end
            end
            srr_pkg::SRR_DEV_SREF: begin
                if (is_srx) begin
                    next_state = srr_pkg::SRR_DEV_EXIT;
                end
            end
            srr_pkg::SRR_DEV_EXIT: begin
                if (tmr_done) begin
                    next_state = srr_pkg::SRR_DEV_DLL;
                end
            end
            srr_pkg::SRR_DEV_DLL: begin
                if (is_ref) begin
                    next_state = srr_pkg::SRR_DEV_REF;
                end else if (tmr_done) begin
                    next_state = srr_pkg::SRR_DEV_IDLE;
                end
            end
            default: next_state = srr_pkg::SRR_DEV_IDLE;
        endcase
    end

    // state, timers and counter
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state       <= srr_pkg::SRR_DEV_IDLE;
            cke_q       <= 1'b0;
            tmr         <= 16'h0000;
            sref_tmr    <= 16'h0000;
            ref_row_o   <= '0;
            ref_count_o <= '0;
        end else begin
            state <= next_state;
            cke_q <= link.cke;
            if (is_ref && ref_ok) begin
                tmr <= 16'(`SRR_TRFC_CYC - 1);
            end else if (is_srx && state == srr_pkg::SRR_DEV_SREF) begin
                tmr <= abort_en_i ? 16'(`SRR_TXS_ABORT_CYC - 1) : 16'(`SRR_TXS_CYC - 1);
            end else if (state == srr_pkg::SRR_DEV_EXIT && tmr_done) begin
                tmr <= 16'(TXSDLL_CYC - `SRR_TXS_CYC);
            end else if (!tmr_done) begin
                tmr <= tmr - 16'h0001;
            end
            if (is_sre && state == srr_pkg::SRR_DEV_IDLE) begin
                sref_tmr <= 16'(`SRR_TCKE_CYC - 1);
            end else if (int_ref) begin
                sref_tmr <= 16'(TREFI_CYC - 1);
            end else if (sref_tmr != 16'h0000) begin
                sref_tmr <= sref_tmr - 16'h0001;
            end
            // internal row counter, external address ignored
            if (do_ref) begin
                ref_row_o   <= ref_row_o + `SRR_ROW_W'(1);
                ref_count_o <= ref_count_o + `SRR_CNT_W'(1);
            end else if (is_srx && abort_en_i && state == srr_pkg::SRR_DEV_SREF
                         && sref_tmr > 16'(TREFI_CYC - `SRR_TRFC_CYC)) begin
                // aborted refresh does not advance counter
                ref_row_o   <= ref_row_o - `SRR_ROW_W'(1);
                ref_count_o <= ref_count_o - `SRR_CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // status, termination and dll
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o       <= 1'b0;
            banks_idle_o <= 1'b1;
            in_sref_o    <= 1'b0;
            rtt_park_o   <= 1'b0;
            dll_on_o     <= 1'b0;
            dll_reset_o  <= 1'b0;
            cmd_err_o    <= 1'b0;
        end else begin
            busy_o       <= (next_state != srr_pkg::SRR_DEV_IDLE);
            banks_idle_o <= 1'b1;
            in_sref_o    <= (next_state == srr_pkg::SRR_DEV_SREF);
            // hi-z in self refresh, park restored on exit
            rtt_park_o   <= park_en_i && (next_state != srr_pkg::SRR_DEV_SREF);
            // dll follows self refresh, reset on exit
            dll_on_o     <= dll_used_i && (next_state != srr_pkg::SRR_DEV_SREF);
            dll_reset_o  <= dll_used_i && is_srx && state == srr_pkg::SRR_DEV_SREF;
            // sticky flag for non-deselect during a blocking window
            if ((state == srr_pkg::SRR_DEV_REF || state == srr_pkg::SRR_DEV_EXIT)
                && !is_des) begin
                cmd_err_o <= 1'b1;
            end
        end
    end
endmodule

// File: src/srr_controller.sv
`timescale 1ns/100ps
`include "srr_params.svh"
// controller end: refresh scheduling with postpone/pull-in, self refresh
module srr_controller #(
    parameter int TREFI_CYC  = `SRR_TREFI_CYC,
    parameter int TXSDLL_CYC = `SRR_TXSDLL_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    srr_link_if.ctl                      link,
    input  wire srr_pkg::srr_mode_t      mode_i,
    input  wire logic                    ref_req_i,
    input  wire logic                    sre_req_i,
    input  wire logic                    srx_req_i,
    input  wire logic                    abort_en_i,
    output logic                         idle_o,
    output logic                         in_sref_o,
    output logic [`SRR_DEBT_W-1:0]       debt_o
);
    srr_pkg::srr_ctl_t           state;
    logic [15:0]                 tmr;
    logic [15:0]                 refi_tmr;
    logic signed [`SRR_DEBT_W-1:0] debt;
    logic                        extra_owed;
    logic [`SRR_DEBT_W-1:0]      lim;
    logic                        tmr_done;
    logic                        must_ref;
    logic                        can_ref;
    logic                        go_ref;
    logic                        go_sre;
    logic [15:0]                 refi_cyc;
    logic [15:0]                 gap_tmr;

    // ------------------------------------------------------------------
    // debt limits
    // ------------------------------------------------------------------
    // postponement limit per mode
    assign lim = (mode_i == srr_pkg::SRR_MODE_4X) ? `SRR_DEBT_W'(4 * `SRR_POST_1X) :
                 (mode_i == srr_pkg::SRR_MODE_2X) ? `SRR_DEBT_W'(2 * `SRR_POST_1X) :
                 `SRR_DEBT_W'(`SRR_POST_1X);
    assign refi_cyc = (mode_i == srr_pkg::SRR_MODE_4X) ? 16'(TREFI_CYC / 4) :
                      (mode_i == srr_pkg::SRR_MODE_2X) ? 16'(TREFI_CYC / 2) :
                      16'(TREFI_CYC);
    assign tmr_done = (tmr == 16'h0000);
    // force refresh one short of the limit, keeps gap under limit+1
    // also force after eight 1x intervals, whatever the pull-in credit
    assign must_ref = (debt >= $signed(lim - `SRR_DEBT_W'(1))) ||
                      (gap_tmr >= 16'(`SRR_POST_1X * TREFI_CYC));
    // pull-in beyond limit gives no credit, so stop there
    // never more than lim early also caps bursts
    assign can_ref  = (debt > -$signed(lim));
    // only from idle, where all banks are precharged
    assign go_ref   = (state == srr_pkg::SRR_CTL_IDLE) &&
                      (must_ref || extra_owed || (ref_req_i && can_ref)) && tmr_done;
    // reentry only after the extra refresh
    assign go_sre   = (state == srr_pkg::SRR_CTL_IDLE) && sre_req_i && !go_ref
                      && !extra_owed && tmr_done;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state      <= srr_pkg::SRR_CTL_IDLE;
            tmr        <= 16'(`SRR_TRP_CYC);
            extra_owed <= 1'b0;
        end else begin
            if (!tmr_done) begin
                tmr <= tmr - 16'h0001;
            end
            case (state)
                srr_pkg::SRR_CTL_IDLE: begin
                    if (go_ref) begin
                        state      <= srr_pkg::SRR_CTL_TRFC;
                        tmr        <= 16'(`SRR_TRFC_CYC - 1);
                        extra_owed <= 1'b0;
                    end else if (go_sre) begin
                        state <= srr_pkg::SRR_CTL_ENDES;
                        tmr   <= 16'(`SRR_TCKSRE_CYC);
                    end
                end
                srr_pkg::SRR_CTL_TRFC: begin
                    if (tmr_done) begin
                        state <= srr_pkg::SRR_CTL_IDLE;
                    end
                end
                srr_pkg::SRR_CTL_ENDES: begin
                    state <= srr_pkg::SRR_CTL_SREF;
                end
                srr_pkg::SRR_CTL_SREF: begin
                    // stay at least tCKESR and tCKSRE
                    if (tmr_done && srx_req_i) begin
                        state <= srr_pkg::SRR_CTL_CKRUN;
                        tmr   <= 16'(`SRR_TCKSRX_CYC);
                    end
                end
                srr_pkg::SRR_CTL_CKRUN: begin
                    // clock stable tCKSRX before cke rises
                    if (tmr_done) begin
                        state      <= srr_pkg::SRR_CTL_EXIT;
                        extra_owed <= 1'b1;
                        // full wait covers tXS and tXS_abort
                        tmr        <= 16'(TXSDLL_CYC - 1);
                    end
                end
                srr_pkg::SRR_CTL_EXIT: begin
                    if (tmr_done) begin
                        state <= srr_pkg::SRR_CTL_IDLE;
                    end
                end
                default: state <= srr_pkg::SRR_CTL_IDLE;
            endcase
        end
    end

    // interval timer and signed debt; self refresh clears the debt
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refi_tmr <= 16'h0000;
            debt     <= '0;
            gap_tmr  <= 16'h0000;
        end else begin
            refi_tmr <= (refi_tmr == 16'h0000) ? refi_cyc - 16'h0001 : refi_tmr - 16'h0001;
            // cycles since the last refresh, held at zero in self refresh
            gap_tmr  <= (go_ref || state == srr_pkg::SRR_CTL_SREF) ? 16'h0000
                                                                  : gap_tmr + 16'h0001;
            if (state == srr_pkg::SRR_CTL_SREF) begin
                debt <= '0;
            end else if (go_ref && refi_tmr != 16'h0000) begin
                debt <= debt - `SRR_DEBT_W'(1);
            end else if (!go_ref && refi_tmr == 16'h0000) begin
                debt <= debt + `SRR_DEBT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.cs_n  <= 1'b1;
            link.act_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n  <= 1'b1;
            link.cke   <= 1'b0;
            link.odt   <= 1'b0;
            link.ck_en <= 1'b1;
            link.addr  <= '0;
            idle_o     <= 1'b0;
            in_sref_o  <= 1'b0;
            debt_o     <= '0;
        end else begin
            // refresh or entry code, else deselect
            link.cs_n  <= !(go_ref || go_sre);
            link.ras_n <= !(go_ref || go_sre);
            link.cas_n <= !(go_ref || go_sre);
            link.act_n <= 1'b1;
            link.we_n  <= 1'b1;
            // cke high and odt low through exit
            link.cke   <= !(go_sre || state == srr_pkg::SRR_CTL_ENDES ||
                            state == srr_pkg::SRR_CTL_SREF ||
                            (state == srr_pkg::SRR_CTL_CKRUN && !tmr_done));
            link.odt   <= 1'b0;
            // clock stopped only inside self refresh
            link.ck_en <= !(state == srr_pkg::SRR_CTL_SREF && tmr_done && !srx_req_i);
            link.addr  <= '0;
            idle_o     <= (state == srr_pkg::SRR_CTL_IDLE);
            in_sref_o  <= (state == srr_pkg::SRR_CTL_SREF);
            debt_o     <= debt;
        end
    end
endmodule

// File: verification/srr_link_monitor.sv
`timescale 1ns/100ps
`include "srr_params.svh"
// watches the command bus between controller and device
module srr_link_monitor #(
    parameter int TREFI_CYC  = `SRR_TREFI_CYC,
    parameter int TXSDLL_CYC = `SRR_TXSDLL_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cs_n,
    input  wire logic        act_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        cke,
    input  wire logic        odt,
    input  wire logic        ck_en,
    input  wire logic [14:0] addr
);
    // ------------------------------------------------------------
    // command decode and window counters
    // ------------------------------------------------------------
    logic        cke_q, in_sr, need_ref;
    logic [7:0]  rfc_cnt, xs_cnt, ckr_cnt;
    logic [15:0] dll_cnt, gap_cnt;
    wire ref_code = !cs_n && !ras_n && !cas_n && we_n && act_n;
    wire ref_cmd  = ref_code && cke && cke_q;
    wire sre_cmd  = ref_code && !cke && cke_q;
    wire srx_cmd  = cke && !cke_q && in_sr;
    // rfc_cnt, xs_cnt and dll_cnt reload on their command and count down the blocking time; ckr_cnt and gap_cnt count up
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {cke_q, in_sr, need_ref} <= 3'h0;
            {rfc_cnt, xs_cnt, ckr_cnt} <= 24'h0;
            {dll_cnt, gap_cnt} <= 32'h0;
        end else begin
            cke_q    <= cke;
            in_sr    <= sre_cmd ? 1'b1 : (cke ? 1'b0 : in_sr);
            need_ref <= srx_cmd ? 1'b1 : (ref_cmd ? 1'b0 : need_ref);
            rfc_cnt  <= ref_cmd ? 8'(`SRR_TRFC_CYC - 1) : rfc_cnt - 8'(rfc_cnt != 8'h0);
            xs_cnt   <= srx_cmd ? 8'(`SRR_TXS_CYC - 1) : xs_cnt - 8'(xs_cnt != 8'h0);
            dll_cnt  <= srx_cmd ? 16'(TXSDLL_CYC - 1) : dll_cnt - 16'(dll_cnt != 16'h0);
            ckr_cnt  <= !ck_en ? 8'h0 : ckr_cnt + 8'(ckr_cnt != 8'hff);
            gap_cnt  <= (ref_cmd || !cke) ? 16'h0 : gap_cnt + 16'h1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_ref_des_hold: assert property (rfc_cnt != 8'h0 |-> cs_n)
        else $error("command inside refresh busy window");
    a_sre_des_next: assert property (sre_cmd |=> cs_n)
        else $error("no deselect after self refresh entry");
    a_cke_low_hold: assert property (sre_cmd |-> (!cke)[*6])
        else $error("cke rose before minimum self refresh time");
    a_clk_stop_late: assert property (sre_cmd |=> ck_en[*8] ##1 ck_en)
        else $error("clock stopped too soon after entry");
    a_clk_run_exit: assert property (srx_cmd |-> ckr_cnt >= 8'(`SRR_TCKSRX_CYC))
        else $error("clock not stable long enough before exit");
    a_exit_des_cmd: assert property (srx_cmd |-> cs_n)
        else $error("exit without deselect");
    a_exit_des_hold: assert property (xs_cnt != 8'h0 |-> cs_n)
        else $error("command inside exit delay");
    a_exit_odt_low: assert property (dll_cnt != 16'h0 |-> !odt && cke && cs_n)
        else $error("odt, cke or command wrong during dll relock");
    a_extra_ref_first: assert property (sre_cmd |-> !need_ref)
        else $error("self refresh reentered without extra refresh");
    a_ref_gap_max: assert property (gap_cnt <= 16'(9 * TREFI_CYC))
        else $error("refresh gap too long");
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
`include "srr_params.svh"
module tb;
    localparam int         TREFI    = 120; // 4x interval stays above tRFC
    localparam int         TDLL     = 40;
    localparam int         TRFC     = `SRR_TRFC_CYC;
    localparam logic [4:0] REF_CODE = 5'h03;
    logic                  clk_i     = 1'b0;
    logic                  sys_rst_i = 1'b1;
    srr_pkg::srr_mode_t    mode      = srr_pkg::SRR_MODE_1X;
    logic                  ref_req   = 1'b0;
    logic                  sre_req   = 1'b0;
    logic                  srx_req   = 1'b0;
    logic                  abort_en  = 1'b0;
    logic                  park_en   = 1'b1;
    logic                  c_idle, c_sref, d_busy, d_banks, d_sref, d_park, d_dll, d_dllr;
    logic                  d_err, e_busy, e_banks, e_err;
    logic [7:0]            c_debt;
    logic [7:0]            lo;
    logic [14:0]           d_row, e_row;
    logic [15:0]           d_cnt, e_cnt, c0, r0;
    logic [15:0]           nref      = 16'h0;
    int                    bad_count = 0;
    int                    tests_run = 0;
    srr_link_if lk ();
    srr_link_if lk2 ();
    srr_controller #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TDLL)) srr_controller_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lk.ctl), .mode_i(mode), .ref_req_i(ref_req),
        .sre_req_i(sre_req), .srx_req_i(srx_req), .abort_en_i(abort_en), .idle_o(c_idle),
        .in_sref_o(c_sref), .debt_o(c_debt));
    srr_device #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TDLL)) srr_device_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lk.dev), .abort_en_i(abort_en),
        .park_en_i(park_en), .dll_used_i(1'b1), .busy_o(d_busy), .banks_idle_o(d_banks),
        .in_sref_o(d_sref), .rtt_park_o(d_park), .dll_on_o(d_dll), .dll_reset_o(d_dllr),
        .ref_row_o(d_row), .ref_count_o(d_cnt), .cmd_err_o(d_err));
    // second device, driven by the bench so that faults can be injected
    srr_device #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TDLL)) srr_device_x_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lk2.dev), .abort_en_i(1'b0),
        .park_en_i(park_en), .dll_used_i(1'b1), .busy_o(e_busy), .banks_idle_o(e_banks),
        .in_sref_o(), .rtt_park_o(), .dll_on_o(), .dll_reset_o(), .ref_row_o(e_row),
        .ref_count_o(e_cnt), .cmd_err_o(e_err));
    srr_link_monitor #(.TREFI_CYC(TREFI), .TXSDLL_CYC(TDLL)) srr_link_monitor_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(lk.cs_n), .act_n(lk.act_n),
        .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .cke(lk.cke), .odt(lk.odt),
        .ck_en(lk.ck_en), .addr(lk.addr));
    // clock and refresh count seen on the wire
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (lk.cke && {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n, lk.act_n} === REF_CODE) begin
            nref <= nref + 16'h1;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++) begin
            @(negedge clk_i);
        end
    endtask
    // one command for one cycle, then a deselect with the bus turned over
    task automatic cmd2(input logic [4:0] p, input logic [14:0] a);
        {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n, lk2.act_n} = p;
        lk2.addr = a;
        @(negedge clk_i);
        {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n, lk2.act_n} = 5'h1f;
        lk2.addr = ~a;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n, lk2.act_n} = 5'h1f;
        {lk2.cke, lk2.odt, lk2.ck_en, lk2.addr} = {3'h5, 15'h0};
        void'($urandom(32'h76cc2f6d));
        cyc(10);
        sys_rst_i = 1'b0;
        cyc(5);
        check("banks idle", e_banks, 1'b1);
        check("controller idle", c_idle, 1'b1);
        // each code with one pin flipped must not refresh
        for (int i = 0; i < 5; i++) begin
            c0 = e_cnt;
            cmd2(REF_CODE ^ (5'h01 << i), 15'($urandom));
            cyc(TRFC + 2);
            check("flipped code count", e_cnt, c0);
        end
        $display("test decode done");
        // refreshes with random address, then one inside the busy window
        for (int i = 0; i < 2; i++) begin
            c0 = e_cnt;
            r0 = 16'(e_row);
            cmd2(REF_CODE, 15'($urandom));
            check("refresh busy", e_busy, 1'b1);
            check("refresh row", e_row, 15'(r0 + 16'h1));
            check("refresh count", e_cnt, c0 + 16'h1);
            cyc(TRFC - 3);
            check("busy held", e_busy, 1'b1);
            cyc(4);
            check("busy over", e_busy, 1'b0);
            check("banks after", e_banks, 1'b1);
        end
        check("no error yet", e_err, 1'b0);
        cmd2(REF_CODE, 15'($urandom));
        cyc(4);
        c0 = e_cnt;
        cmd2(REF_CODE, 15'($urandom));
        check("early refresh ignored", e_cnt, c0);
        check("early refresh flagged", e_err, 1'b1);
        $display("test refresh window done");
        // pull-in held on: credit stops at the 1x limit
        ref_req = 1'b1;
        cyc(18 * TREFI);
        // lowest debt over two intervals: reaches the limit, never past it
        lo = 8'h7f;
        repeat (2 * TREFI) begin
            cyc(1);
            if ($signed(c_debt) < $signed(lo)) begin
                lo = c_debt;
            end
        end
        check("pull-in limit", lo, 8'hf8);
        ref_req = 1'b0;
        $display("test pull-in done");
        // random modes and early requests
        for (int i = 0; i < 40; i++) begin
            mode = srr_pkg::srr_mode_t'($urandom_range(2));
            ref_req = 1'($urandom_range(1));
            cyc($urandom_range(70, 5));
        end
        ref_req = 1'b0;
        cyc(2);
        check("device count", d_cnt, nref);
        check("device row", d_row, nref[14:0]);
        check("no device error", d_err, 1'b0);
        $display("test random refresh done");
        // self refresh entry and exit, plain and with abort
        for (int k = 0; k < 2; k++) begin
            abort_en = 1'(k);
            park_en = 1'($urandom_range(1));
            sre_req = 1'b1;
            wait_hi(d_sref, 400);
            cyc(1);
            sre_req = 1'b0;
            c0 = d_cnt;
            check("in self refresh", d_sref, 1'b1);
            check("park off", d_park, 1'b0);
            check("dll off", d_dll, 1'b0);
            check("device busy", d_busy, 1'b1);
            check("controller not idle", c_idle, 1'b0);
            cyc(`SRR_TCKE_CYC + 1);
            check("first internal refresh", d_cnt != c0, 1'b1);
            c0 = d_cnt;
            cyc(TREFI + 2);
            check("timer refresh", d_cnt != c0, 1'b1);
            srx_req = 1'b1;
            wait_hi(d_dllr, 100);
            check("dll reset pulse", d_dllr, 1'b1);
            srx_req = 1'b0;
            cyc(TDLL + 5);
            check("out of self refresh", {d_sref, c_sref}, 2'h0);
            check("dll back on", d_dll, 1'b1);
            check("park restored", d_park, park_en);
            check("exit clean", d_err, 1'b0);
            check("banks after exit", d_banks, 1'b1);
            check("sref refresh count", d_cnt, c0 + 16'(2 - k));
        end
        $display("test self refresh done");
        report_and_stop();
    end
    // watchdog well beyond the expected run length
    initial begin
        #(20000 * 10);
        bad_count++;
        report_and_stop();
    end
endmodule
